/* rtl/mcu_core_exec.sv */
// Instruction execution core with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module mcu_core_exec
  import mcu_core_pkg::*;
#(
  parameter int WDOG_TIMEOUT_CYCLES = 65536
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic sysClkStop
);

  typedef enum logic {EX_READY, EX_DUMMY} exec_e;
  typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} pre_e;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  exec_e stateReg;
  pre_e preLastReg;
  logic [DATA_W-1:0] accReg;
  logic cReg;
  logic acReg;
  logic zReg;
  logic ovReg;
  logic pdfReg;
  logic [PC_W-1:0] pcReg;
  logic [31:0] operandReg;
  logic [DATA_W-1:0] memReg [MEM_DEPTH];
  logic [PC_W-1:0] stackReg [STACK_DEPTH];
  logic [STACK_AW-1:0] spReg;
  logic dphValidReg;
  logic dphWriteReg;
  logic [7:0] dphAddrReg;
  logic [WDOG_W-1:0] wdogCount;
  logic wdogExpired;

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  logic addrPhase;
  assign addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dphValidReg <= 1'b0;
      dphWriteReg <= 1'b0;
      dphAddrReg <= 8'h00;
    end else if (hready) begin
      dphValidReg <= addrPhase;
      dphWriteReg <= hwrite;
      dphAddrReg <= haddr[7:0];
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  function automatic logic isMem(input logic [7:0] a);
    return a[7:6] == MEM_REGION;
  endfunction

  // ----------------------------------------------------------------
  // Decode of the instruction written in the data phase
  // ----------------------------------------------------------------
  logic dataWr;
  logic go;
  op_e op;
  logic [MEM_AW-1:0] memIdx;
  logic [2:0] bitSel;
  logic [DATA_W-1:0] memRd;
  logic [DATA_W-1:0] aluRes;
  logic aluC;
  logic aluAc;
  logic aluZ;
  logic aluOv;
  logic toMem;
  logic toAcc;
  logic pclWrite;
  logic twoCycle;
  logic preFire;
  logic wdogClr;
  logic [PC_W-1:0] pcNext;
  logic [PC_W-1:0] stackTop;

  assign dataWr = dphValidReg && dphWriteReg;
  // Sleep or the dummy slot of a two-cycle instruction refuses new instructions
  assign go = dataWr && (dphAddrReg == OFF_INSTR) && (stateReg == EX_READY)
              && !sysClkStop;
  assign op = op_e'(hwdata[INSTR_OP_LSB +: 5]);
  assign bitSel = hwdata[INSTR_BIT_LSB +: 3];
  assign memIdx = hwdata[INSTR_ADDR_LSB +: MEM_AW];
  assign memRd = (memIdx == PCL_IDX) ? pcReg[DATA_W-1:0] : memReg[memIdx];
  assign stackTop = stackReg[spReg - STACK_AW'(1)];

  alu_core u_alu (
    .op(op),
    .acc(accReg),
    .mem(memRd),
    .imm(operandReg[DATA_W-1:0]),
    .bitSel(bitSel),
    .cIn(cReg),
    .acIn(acReg),
    .zIn(zReg),
    .ovIn(ovReg),
    .result(aluRes),
    .cOut(aluC),
    .acOut(aluAc),
    .zOut(aluZ),
    .ovOut(aluOv)
  );

  always_comb begin
    toMem = 1'b0;
    toAcc = 1'b0;
    case (op)
      OP_SUM_TO_MEM, OP_SUMC_TO_MEM, OP_CONJ_TO_MEM, OP_DISJ_TO_MEM, OP_INVERT_TO_MEM,
      OP_BCD_ADJUST, OP_MINUS_ONE_TO_MEM, OP_PLUS_ONE_TO_MEM, OP_COPY_TO_MEM,
      OP_CLEAR_BYTE, OP_CLEAR_BIT: toMem = 1'b1;
      OP_SUM_TO_ACC, OP_SUMC_TO_ACC, OP_SUM_IMM, OP_CONJ_TO_ACC, OP_CONJ_IMM,
      OP_DISJ_TO_ACC, OP_DISJ_IMM, OP_INVERT_TO_ACC, OP_MINUS_ONE_TO_ACC,
      OP_PLUS_ONE_TO_ACC, OP_COPY_TO_ACC, OP_COPY_IMM, OP_POP_WITH_IMM:
        toAcc = 1'b1;
      default: toAcc = 1'b0;
    endcase
  end

  assign pclWrite = go && toMem && (memIdx == PCL_IDX);
  assign twoCycle = pclWrite || op == OP_SUBROUTINE_JUMP || op == OP_GOTO_ADDRESS
                    || op == OP_POP_TO_COUNTER || op == OP_POP_WITH_IMM;
  assign preFire = go && ((op == OP_WATCHDOG_PRECLEAR_FIRST && preLastReg == PRE_SECOND)
                   || (op == OP_WATCHDOG_PRECLEAR_SECOND && preLastReg == PRE_FIRST));
  assign wdogClr = (go && (op == OP_WATCHDOG_CLEAR || op == OP_SLEEP)) || preFire;

  always_comb begin
    pcNext = pcReg + PC_STEP;
    if (pclWrite) begin
      pcNext = {pcReg[PC_W-1:DATA_W], aluRes};
    end else begin
      case (op)
        OP_SUBROUTINE_JUMP, OP_GOTO_ADDRESS:
          pcNext = operandReg[OPND_TGT_LSB +: PC_W];
        OP_POP_TO_COUNTER, OP_POP_WITH_IMM: pcNext = stackTop;
        default: pcNext = pcReg + PC_STEP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencing: a dummy slot follows each two-cycle instruction
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= EX_READY;
    end else begin
      case (stateReg)
        EX_READY: stateReg <= (go && twoCycle) ? EX_DUMMY : EX_READY;
        EX_DUMMY: stateReg <= EX_READY;
        default: stateReg <= EX_READY;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pcReg <= PC_RESET;
    end else if (go) begin
      pcReg <= pcNext;
    end
  end

  // ----------------------------------------------------------------
  // Stack
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spReg <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stackReg[i] <= PC_RESET;
      end
    end else if (go && op == OP_SUBROUTINE_JUMP) begin
      stackReg[spReg] <= pcReg + PC_STEP;
      spReg <= spReg + STACK_AW'(1);
    end else if (go && (op == OP_POP_TO_COUNTER || op == OP_POP_WITH_IMM)) begin
      spReg <= spReg - STACK_AW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, data memory, operand
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accReg <= BYTE_ZERO;
    end else if (go && toAcc) begin
      accReg <= aluRes;
    end else if (dataWr && dphAddrReg == OFF_ACC) begin
      accReg <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        memReg[i] <= BYTE_ZERO;
      end
    end else if (go && toMem && !pclWrite) begin
      memReg[memIdx] <= aluRes;
    end else if (dataWr && isMem(dphAddrReg)) begin
      memReg[dphAddrReg[2 +: MEM_AW]] <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      operandReg <= 32'h00000000;
    end else if (dataWr && dphAddrReg == OFF_OPERAND) begin
      operandReg <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cReg <= 1'b0;
      acReg <= 1'b0;
      zReg <= 1'b0;
      ovReg <= 1'b0;
    end else if (go) begin
      cReg <= aluC;
      acReg <= aluAc;
      zReg <= aluZ;
      ovReg <= aluOv;
    end else if (dataWr && dphAddrReg == OFF_STATUS) begin
      cReg <= hwdata[ST_C];
      acReg <= hwdata[ST_AC];
      zReg <= hwdata[ST_Z];
      ovReg <= hwdata[ST_OV];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pdfReg <= 1'b0;
    end else if (go && op == OP_SLEEP) begin
      pdfReg <= 1'b1;
    end else if ((go && op == OP_WATCHDOG_CLEAR) || preFire) begin
      pdfReg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preLastReg <= PRE_NONE;
    end else if (go) begin
      case (op)
        OP_WATCHDOG_PRECLEAR_FIRST: preLastReg <= preFire ? PRE_NONE : PRE_FIRST;
        OP_WATCHDOG_PRECLEAR_SECOND: preLastReg <= preFire ? PRE_NONE : PRE_SECOND;
        default: preLastReg <= PRE_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power-down and watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sysClkStop <= 1'b0;
    end else if (go && op == OP_SLEEP) begin
      sysClkStop <= 1'b1;
    end else if (dataWr && dphAddrReg == OFF_CTRL && hwdata[CTRL_WAKE]) begin
      sysClkStop <= 1'b0;
    end
  end

  watchdog_timer #(
    .TIMEOUT_CYCLES(WDOG_TIMEOUT_CYCLES)
  ) u_wdog (
    .clk(clk),
    .arst_n(arst_n),
    .clearAll(wdogClr),
    .count(wdogCount),
    .expired(wdogExpired)
  );

  // ----------------------------------------------------------------
  // Read data, registered at the address phase
  // ----------------------------------------------------------------
  function automatic logic [31:0] readWord(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    if (isMem(a)) begin
      w[DATA_W-1:0] = (a[2 +: MEM_AW] == PCL_IDX) ? pcReg[DATA_W-1:0] : memReg[a[2 +: MEM_AW]];
    end else begin
      case (a)
        OFF_OPERAND: w = operandReg;
        OFF_ACC: w[DATA_W-1:0] = accReg;
        OFF_STATUS: begin
          w[ST_C] = cReg;
          w[ST_AC] = acReg;
          w[ST_Z] = zReg;
          w[ST_OV] = ovReg;
          w[ST_PDF] = pdfReg;
          w[ST_TO] = wdogExpired;
          w[ST_BUSY] = (stateReg == EX_DUMMY);
          w[ST_SLEEP] = sysClkStop;
        end
        OFF_PC: w[PC_W-1:0] = pcReg;
        OFF_WDOG: w[WDOG_W-1:0] = wdogCount;
        default: w = 32'h00000000;
      endcase
    end
    return w;
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= readWord(haddr[7:0]);
    end
  end

endmodule
`default_nettype wire

/* shared/mcu_core_pkg.sv */
// Constants, opcodes and register map of the instruction execution core
package mcu_core_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int STACK_AW = 2;
  localparam int STACK_DEPTH = 4;
  localparam int WDOG_W = 17;

  // ----------------------------------------------------------------
  // Register map (byte offsets, decoded on haddr[7:0])
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_WDOG = 8'h14;
  localparam logic [7:0] OFF_CTRL = 8'h18;
  localparam logic [1:0] MEM_REGION = 2'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int INSTR_OP_LSB = 0;
  localparam int INSTR_BIT_LSB = 8;
  localparam int INSTR_ADDR_LSB = 16;
  localparam int OPND_TGT_LSB = 8;
  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_PDF = 4;
  localparam int ST_TO = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_SLEEP = 7;
  localparam int CTRL_WAKE = 0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [MEM_AW-1:0] PCL_IDX = 4'h2;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [DATA_W-1:0] BCD_LOW_ADJ = 8'h06;
  localparam logic [DATA_W-1:0] BCD_HIGH_ADJ = 8'h60;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [PC_W-1:0] PC_STEP = 12'h001;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;

  typedef enum logic [4:0] {
    OP_IDLE, OP_SUM_TO_ACC, OP_SUM_TO_MEM, OP_SUMC_TO_ACC, OP_SUMC_TO_MEM,
    OP_SUM_IMM, OP_CONJ_TO_ACC, OP_CONJ_IMM, OP_CONJ_TO_MEM, OP_DISJ_TO_ACC,
    OP_DISJ_IMM, OP_DISJ_TO_MEM, OP_INVERT_TO_MEM, OP_INVERT_TO_ACC,
    OP_BCD_ADJUST, OP_MINUS_ONE_TO_MEM, OP_MINUS_ONE_TO_ACC, OP_PLUS_ONE_TO_MEM,
    OP_PLUS_ONE_TO_ACC, OP_COPY_TO_ACC, OP_COPY_IMM, OP_COPY_TO_MEM,
    OP_CLEAR_BYTE, OP_CLEAR_BIT, OP_SUBROUTINE_JUMP, OP_GOTO_ADDRESS,
    OP_POP_TO_COUNTER, OP_POP_WITH_IMM, OP_WATCHDOG_CLEAR,
    OP_WATCHDOG_PRECLEAR_FIRST, OP_WATCHDOG_PRECLEAR_SECOND, OP_SLEEP
  } op_e;

endpackage

/* rtl/alu_core.sv */
// Combinational arithmetic and logic unit with flag generation
`timescale 1ns/1ps
`default_nettype none
module alu_core
  import mcu_core_pkg::*;
(
  input wire op_e op,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [DATA_W-1:0] mem,
  input wire logic [DATA_W-1:0] imm,
  input wire logic [2:0] bitSel,
  input wire logic cIn,
  input wire logic acIn,
  input wire logic zIn,
  input wire logic ovIn,
  output logic [DATA_W-1:0] result,
  output logic cOut,
  output logic acOut,
  output logic zOut,
  output logic ovOut
);

  // Sum with carry out of bit 7 and bit 3 and signed overflow, packed {ov,ac,c,sum}
  function automatic logic [10:0] addByte(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    logic ovf;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    ovf = (a[7] == b[7]) && (full[7] != a[7]);
    return {ovf, low[4], full[8], full[7:0]};
  endfunction

  logic [10:0] addOut;
  logic [8:0] bcdSum;
  logic [DATA_W-1:0] bcdAdj;

  always_comb begin
    addOut = 11'h000;
    bcdAdj = BYTE_ZERO;
    bcdSum = 9'h000;
    result = acc;
    cOut = cIn;
    acOut = acIn;
    zOut = zIn;
    ovOut = ovIn;
    case (op)
      OP_SUM_TO_ACC, OP_SUM_TO_MEM, OP_SUMC_TO_ACC, OP_SUMC_TO_MEM, OP_SUM_IMM: begin
        addOut = addByte(acc, (op == OP_SUM_IMM) ? imm : mem,
                         (op == OP_SUMC_TO_ACC || op == OP_SUMC_TO_MEM) && cIn);
        result = addOut[7:0];
        cOut = addOut[8];
        acOut = addOut[9];
        ovOut = addOut[10];
        zOut = (addOut[7:0] == BYTE_ZERO);
      end
      OP_CONJ_TO_ACC, OP_CONJ_TO_MEM, OP_CONJ_IMM: begin
        result = acc & ((op == OP_CONJ_IMM) ? imm : mem);
        zOut = (result == BYTE_ZERO);
      end
      OP_DISJ_TO_ACC, OP_DISJ_TO_MEM, OP_DISJ_IMM: begin
        result = acc | ((op == OP_DISJ_IMM) ? imm : mem);
        zOut = (result == BYTE_ZERO);
      end
      OP_INVERT_TO_MEM, OP_INVERT_TO_ACC: begin
        result = ~mem;
        zOut = (result == BYTE_ZERO);
      end
      OP_MINUS_ONE_TO_MEM, OP_MINUS_ONE_TO_ACC: begin
        result = mem - BYTE_ONE;
        zOut = (result == BYTE_ZERO);
      end
      OP_PLUS_ONE_TO_MEM, OP_PLUS_ONE_TO_ACC: begin
        result = mem + BYTE_ONE;
        zOut = (result == BYTE_ZERO);
      end
      OP_BCD_ADJUST: begin
        if (acc[3:0] > BCD_DIGIT_MAX || acIn) begin
          bcdAdj = bcdAdj | BCD_LOW_ADJ;
        end
        if (acc[7:4] > BCD_DIGIT_MAX || cIn) begin
          bcdAdj = bcdAdj | BCD_HIGH_ADJ;
        end
        bcdSum = {1'b0, acc} + {1'b0, bcdAdj};
        result = bcdSum[7:0];
        cOut = cIn | bcdSum[8];
      end
      OP_COPY_TO_ACC: result = mem;
      OP_COPY_IMM, OP_POP_WITH_IMM: result = imm;
      OP_COPY_TO_MEM: result = acc;
      OP_CLEAR_BYTE: result = BYTE_ZERO;
      OP_CLEAR_BIT: result = mem & ~(BYTE_ONE << bitSel);
      default: result = acc;
    endcase
  end

endmodule
`default_nettype wire

/* rtl/watchdog_timer.sv */
// Watchdog prescaler and counter with sticky expiry flag
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
  import mcu_core_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 65536
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clearAll,
  output logic [WDOG_W-1:0] count,
  output logic expired
);

  localparam logic [WDOG_W-1:0] LAST = WDOG_W'(TIMEOUT_CYCLES - 1);

  logic wrap;
  assign wrap = (count == LAST);

  // Low bits act as the prescaler, high bits as the counter; both clear together
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (clearAll || wrap) begin
      count <= '0;
    end else begin
      count <= count + WDOG_W'(1);
    end
  end

  // A clear in the cycle of an expiry wins: the flag is cleared, not set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      expired <= 1'b0;
    end else if (wrap && !clearAll) begin
      expired <= 1'b1;
    end else if (clearAll) begin
      expired <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* tb/mcu_core_exec_assertions.sv */
// Port-level checker for the instruction execution core
`timescale 1ns/1ps
`default_nettype none
module mcu_core_exec_assertions
  import mcu_core_pkg::*;
#(
  parameter int WDOG_TIMEOUT_CYCLES = 65536
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic sysClkStop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic adr;
  assign adr = hsel && htrans[1] && hready;
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  sequence wrAt(logic [7:0] a);
    adr && hwrite && haddr[7:0] == a;
  endsequence
  sequence rdAt(logic [7:0] a);
    adr && !hwrite && haddr[7:0] == a;
  endsequence
  sequence sleepWr;
    wrAt(OFF_INSTR) ##1 hwdata[4:0] == OP_SLEEP;
  endsequence
  sequence wakeWr;
    wrAt(OFF_CTRL) ##1 hwdata[CTRL_WAKE];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_SLEEP_STOP: assert property (sleepWr |=> sysClkStop)
    else $error("sleep did not stop the clock");
  AST_WAKE: assert property (wakeWr |=> !sysClkStop)
    else $error("wake did not restart the clock");
  AST_STOP_CAUSE: assert property ($rose(sysClkStop) |-> $past(adr && hwrite, 2))
    else $error("clock stopped without an instruction");
  AST_RUN_CAUSE: assert property ($fell(sysClkStop) |-> $past(adr && hwrite, 2))
    else $error("clock restarted without a write");
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
  AST_INSTR_READ: assert property (rdAt(OFF_INSTR) |=> hrdata == 32'h0000_0000)
    else $error("instruction register read not zero");
  AST_HOLD: assert property (!(adr && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  AST_BYTE_WIDE: assert property (rdAt(OFF_ACC) |=> hrdata[31:8] == 24'h000000)
    else $error("accumulator wider than a byte");
  AST_WDOG_RANGE: assert property (rdAt(OFF_WDOG) |=> hrdata < WDOG_TIMEOUT_CYCLES)
    else $error("watchdog count past its limit");
endmodule
bind mcu_core_exec mcu_core_exec_assertions #(.WDOG_TIMEOUT_CYCLES(WDOG_TIMEOUT_CYCLES)) chk_u (
  .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sysClkStop(sysClkStop));
`default_nettype wire

/* tb/core_env_model.sv */
// Model of the bus ready loop and of the logic fed by the gated clock
`timescale 1ns/1ps
`default_nettype none
module core_env_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sysClkStop,
  input wire logic hreadyout,
  output logic hready,
  output var int coreTicks
);
  assign hready = hreadyout;
  // Counts only the edges that reach the core while its clock runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) coreTicks <= 0;
    else if (!sysClkStop) coreTicks <= coreTicks + 1;
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench of the instruction execution core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mcu_core_pkg::*;
  typedef struct packed {op_e op; logic [7:0] a, m; logic [3:0] f; logic [7:0] ea, em;
    logic [3:0] ef;} row_s;
  localparam row_s ROWS [25] = '{
    '{OP_SUM_TO_ACC,8'h7F,8'h01,4'h0,8'h80,8'h01,4'hA},
    '{OP_SUM_TO_MEM,8'hFF,8'h01,4'h0,8'hFF,8'h00,4'h7},
    '{OP_SUMC_TO_ACC,8'h0F,8'h00,4'h1,8'h10,8'h00,4'h2},
    '{OP_SUMC_TO_MEM,8'h80,8'h80,4'h1,8'h80,8'h01,4'h9},
    '{OP_SUM_IMM,8'h01,8'hFF,4'h0,8'h00,8'hFF,4'h7},
    '{OP_CONJ_TO_ACC,8'hF0,8'h0F,4'hB,8'h00,8'h0F,4'hF},
    '{OP_CONJ_IMM,8'hF0,8'h3C,4'hF,8'h30,8'h3C,4'hB},
    '{OP_CONJ_TO_MEM,8'h0F,8'hFF,4'h0,8'h0F,8'h0F,4'h0},
    '{OP_DISJ_IMM,8'h10,8'h01,4'h4,8'h11,8'h01,4'h0},
    '{OP_DISJ_TO_MEM,8'h0F,8'hF0,4'h9,8'h0F,8'hFF,4'h9},
    '{OP_INVERT_TO_MEM,8'h12,8'hFF,4'h0,8'h12,8'h00,4'h4},
    '{OP_INVERT_TO_ACC,8'h00,8'h5A,4'h4,8'hA5,8'h5A,4'h0},
    '{OP_BCD_ADJUST,8'h3C,8'h00,4'hD,8'h3C,8'hA2,4'hD},
    '{OP_BCD_ADJUST,8'hA2,8'h00,4'h0,8'hA2,8'h02,4'h1},
    '{OP_MINUS_ONE_TO_MEM,8'h00,8'h00,4'hB,8'h00,8'hFF,4'hB},
    '{OP_MINUS_ONE_TO_ACC,8'h77,8'h01,4'h0,8'h00,8'h01,4'h4},
    '{OP_PLUS_ONE_TO_MEM,8'h00,8'hFF,4'h3,8'h00,8'h00,4'h7},
    '{OP_PLUS_ONE_TO_ACC,8'h00,8'h7F,4'h4,8'h80,8'h7F,4'h0},
    '{OP_COPY_TO_ACC,8'h00,8'h5A,4'hF,8'h5A,8'h5A,4'hF},
    '{OP_COPY_IMM,8'h00,8'hC3,4'h0,8'hC3,8'hC3,4'h0},
    '{OP_COPY_TO_MEM,8'h66,8'h00,4'h5,8'h66,8'h66,4'h5},
    '{OP_CLEAR_BYTE,8'h00,8'hFF,4'hA,8'h00,8'h00,4'hA},
    '{OP_CLEAR_BIT,8'h00,8'hFF,4'h0,8'h00,8'hDF,4'h0},
    '{OP_DISJ_TO_ACC,8'h0F,8'h00,4'h4,8'h0F,8'h00,4'h0},
    '{OP_SUM_TO_ACC,8'h01,8'h01,4'h1,8'h02,8'h01,4'h0}};
  logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, sysClkStop;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  row_s r;
  int nFail, checksDone, ticks, t0;
  mcu_core_exec #(.WDOG_TIMEOUT_CYCLES(64)) dut_u (.clk(clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sysClkStop(sysClkStop));
  core_env_model env_u (.clk(clk), .arst_n(arst_n), .sysClkStop(sysClkStop),
    .hreadyout(hreadyout), .hready(hready), .coreTicks(ticks));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("Checks %0d, failures %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      nFail++;
      report_and_stop();
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    q = hrdata;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e) begin
      nFail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask
  task exe(input op_e op, input logic [3:0] idx);
    xfer(1'b1, OFF_INSTR, {12'h000, idx, 5'h00, 3'h5, 3'h0, op});
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, arst_n, nFail, checksDone} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (ROWS[k]) begin
      r = ROWS[k];
      xfer(1'b1, OFF_ACC, {24'h000000, r.a});
      xfer(1'b1, 8'h4C, {24'h000000, r.m});
      xfer(1'b1, OFF_OPERAND, {24'h000000, r.m});
      xfer(1'b1, OFF_STATUS, {28'h0000000, r.f});
      exe(r.op, 4'h3);
      rdc(OFF_ACC, {24'h000000, r.ea}, 32'hFFFFFFFF);
      rdc(8'h4C, {24'h000000, r.em}, 32'hFFFFFFFF);
      rdc(OFF_STATUS, {28'h0000000, r.ef}, 32'h0000000F);
    end
    $display("Test of data operations done");
    rdc(OFF_INSTR, 32'h0000_0000, 32'hFFFFFFFF);
    xfer(1'b1, OFF_STATUS, 32'h0000_0005);
    xfer(1'b1, OFF_OPERAND, 32'h0001_2300);
    exe(OP_GOTO_ADDRESS, 4'h0);
    rdc(OFF_STATUS, 32'h0000_0040, 32'h0000_0040);
    rdc(OFF_PC, 32'h0000_0123, 32'hFFFFFFFF);
    xfer(1'b1, OFF_OPERAND, 32'h0002_0000);
    exe(OP_SUBROUTINE_JUMP, 4'h0);
    rdc(OFF_PC, 32'h0000_0200, 32'hFFFFFFFF);
    exe(OP_POP_TO_COUNTER, 4'h0);
    rdc(OFF_PC, 32'h0000_0124, 32'hFFFFFFFF);
    xfer(1'b1, OFF_OPERAND, 32'h0003_005A);
    exe(OP_SUBROUTINE_JUMP, 4'h0);
    exe(OP_POP_WITH_IMM, 4'h0);
    rdc(OFF_PC, 32'h0000_0125, 32'hFFFFFFFF);
    rdc(OFF_ACC, 32'h0000_005A, 32'hFFFFFFFF);
    exe(OP_IDLE, 4'h0);
    rdc(OFF_PC, 32'h0000_0126, 32'hFFFFFFFF);
    rdc(OFF_STATUS, 32'h0000_0005, 32'h0000004F);
    exe(OP_COPY_TO_MEM, PCL_IDX);
    rdc(OFF_PC, 32'h0000_015A, 32'hFFFFFFFF);
    rdc(8'h30, 32'h0000_0000, 32'hFFFFFFFF);
    $display("Test of program flow done");
    exe(OP_SLEEP, 4'h0);
    rdc(OFF_STATUS, 32'h0000_0010, 32'h0000_0030);
    chk({31'h0, sysClkStop}, 32'h0000_0001);
    t0 = ticks;
    xfer(1'b1, OFF_OPERAND, 32'h0000_00A5);
    exe(OP_COPY_IMM, 4'h0);
    rdc(OFF_ACC, 32'h0000_005A, 32'hFFFFFFFF);
    chk(ticks, t0);
    xfer(1'b1, OFF_CTRL, 32'h0000_0001);
    repeat (70) @(posedge clk);
    chk({31'h0, sysClkStop}, 32'h0000_0000);
    rdc(OFF_STATUS, 32'h0000_0030, 32'h0000_0030);
    exe(OP_WATCHDOG_PRECLEAR_FIRST, 4'h0);
    exe(OP_WATCHDOG_PRECLEAR_FIRST, 4'h0);
    rdc(OFF_STATUS, 32'h0000_0030, 32'h0000_0030);
    exe(OP_WATCHDOG_PRECLEAR_SECOND, 4'h0);
    rdc(OFF_STATUS, 32'h0000_0000, 32'h0000_0030);
    exe(OP_SLEEP, 4'h0);
    xfer(1'b1, OFF_CTRL, 32'h0000_0001);
    exe(OP_WATCHDOG_CLEAR, 4'h0);
    rdc(OFF_STATUS, 32'h0000_0000, 32'h0000_0030);
    rdc(OFF_WDOG, 32'h0000_0002, 32'hFFFFFFFF);
    $display("Test of power-down and watchdog done");
    report_and_stop();
  end
endmodule
`default_nettype wire
